/* pkg/crf_pkg.sv */
// Constants and types shared by the processor register file
`default_nettype none
package crf_pkg;
  localparam int unsigned CRF_WORD_W = 16;
  localparam logic [15:0] CRF_ADDR_FIRST_ACC = 16'h0000;
  localparam logic [15:0] CRF_ADDR_SECOND_ACC = 16'h0001;
  localparam logic [5:0] CRF_UTIL_SELECT_CODE = 6'h01;
  localparam logic [15:0] CRF_WORD_RESET = 16'h0000;
  localparam logic CRF_FLAG_RESET = 1'b0;
  localparam int unsigned CRF_MSB = 15;

  // Register selector for datapath writes and panel selection
  typedef enum logic [3:0] {
    CRF_SEL_FIRST_ACC,
    CRF_SEL_SECOND_ACC,
    CRF_SEL_MEM_ADDR,
    CRF_SEL_MEM_DATA,
    CRF_SEL_NEXT_INSTR,
    CRF_SEL_UTILITY,
    CRF_SEL_FIRST_INDEX,
    CRF_SEL_SECOND_INDEX,
    CRF_SEL_CARRY_LINK,
    CRF_SEL_OVERFLOW
  } crf_sel_t;

  // Flag operations issued by program instructions
  typedef enum logic [1:0] {
    CRF_FLAG_HOLD,
    CRF_FLAG_SET,
    CRF_FLAG_CLEAR,
    CRF_FLAG_COMPLEMENT
  } crf_flag_op_t;
endpackage : crf_pkg
`default_nettype wire

/* design/crf_flag_unit.sv */
// Sticky carry-link and overflow flag unit
`timescale 1ns/1ps
`default_nettype none
module crf_flag_unit
  import crf_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Program operations
  input wire crf_flag_op_t carry_op_in,
  input wire crf_flag_op_t ovf_op_in,
  // Arithmetic events
  input wire logic carry_event_in,
  input wire logic ovf_event_in,
  // Panel direct load
  input wire logic carry_load_in,
  input wire logic carry_load_val_in,
  input wire logic ovf_load_in,
  input wire logic ovf_load_val_in,
  // Flag state
  output logic carry_out,
  output logic ovf_out
);
  typedef struct packed {
    logic carry;
    logic ovf;
  } crf_flag_state_t;

  crf_flag_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (carry_load_in) begin
      s_d.carry = carry_load_val_in;
    end else begin
      unique case (carry_op_in)
        CRF_FLAG_SET: s_d.carry = 1'b1;
        CRF_FLAG_CLEAR: s_d.carry = 1'b0;
        CRF_FLAG_COMPLEMENT: s_d.carry = ~s_q.carry;
        CRF_FLAG_HOLD: s_d.carry = s_q.carry;
      endcase
    end
    // Carry out only sets; never clears
    if (carry_event_in) begin
      s_d.carry = 1'b1;
    end
    if (ovf_load_in) begin
      s_d.ovf = ovf_load_val_in;
    end else begin
      unique case (ovf_op_in)
        CRF_FLAG_SET: s_d.ovf = 1'b1;
        CRF_FLAG_CLEAR: s_d.ovf = 1'b0;
        default: s_d.ovf = s_q.ovf;
      endcase
    end
    if (ovf_event_in) begin
      s_d.ovf = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '{carry: CRF_FLAG_RESET, ovf: CRF_FLAG_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign carry_out = s_q.carry;
  assign ovf_out = s_q.ovf;

  AST_CARRY_STICKY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.carry && !carry_load_in && carry_op_in == CRF_FLAG_HOLD |=> s_q.carry)
    else $error("carry-link cleared without clear request");
  AST_CARRY_EVENT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    carry_event_in |=> carry_out)
    else $error("carry out did not set carry-link");
  AST_CARRY_COMPL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    carry_op_in == CRF_FLAG_COMPLEMENT && !carry_event_in && !carry_load_in
    |=> carry_out == !$past(carry_out))
    else $error("carry-link complement wrong");
  AST_OVF_EVENT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ovf_event_in |=> ovf_out)
    else $error("overflow event did not set flag");
  AST_OVF_STICKY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ovf_out && !ovf_load_in && ovf_op_in != CRF_FLAG_CLEAR |=> ovf_out)
    else $error("overflow dropped without clear");
  COV_CARRY_SET_BY_EVENT: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    !carry_out ##1 carry_event_in ##1 carry_out);
endmodule : crf_flag_unit
`default_nettype wire

/* design/crf_register_file.sv */
// Programmer-visible register file with memory front and panel display
`timescale 1ns/1ps
`default_nettype none
module crf_register_file
  import crf_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  // Run state
  input wire logic RUN_IN,
  // Datapath register write
  input wire logic DP_WR_EN_IN,
  input wire crf_sel_t DP_WR_SEL_IN,
  input wire logic [15:0] DP_WR_DATA_IN,
  // Memory reference cycle
  input wire logic MEM_REQ_IN,
  input wire logic MEM_WRITE_IN,
  input wire logic [15:0] MEM_ADDR_IN,
  input wire logic [15:0] MEM_WR_DATA_IN,
  input wire logic [15:0] MEM_ARRAY_RD_DATA_IN,
  output logic MEM_ARRAY_WR_EN_OUT,
  output logic [15:0] MEM_ARRAY_ADDR_OUT,
  output logic [15:0] MEM_ARRAY_WR_DATA_OUT,
  output logic [15:0] MEM_RD_DATA_OUT,
  // Utility register I/O path
  input wire logic IO_WR_EN_IN,
  input wire logic IO_RD_EN_IN,
  input wire logic [5:0] IO_SELECT_IN,
  input wire logic [15:0] IO_WR_DATA_IN,
  output logic [15:0] IO_RD_DATA_OUT,
  // Flag operations and events
  input wire crf_flag_op_t CARRY_OP_IN,
  input wire crf_flag_op_t OVF_OP_IN,
  input wire logic CARRY_EVENT_IN,
  input wire logic OVF_EVENT_IN,
  // Operator panel
  input wire crf_sel_t PANEL_SEL_IN,
  input wire logic PANEL_LOAD_DISPLAY_IN,
  input wire logic [15:0] PANEL_SWITCH_DATA_IN,
  input wire logic PANEL_CLEAR_DISPLAY_IN,
  input wire logic PANEL_STORE_IN,
  // Register contents
  output logic [15:0] FIRST_ACC_OUT,
  output logic [15:0] SECOND_ACC_OUT,
  output logic [15:0] MEM_ADDR_OUT,
  output logic [15:0] MEM_DATA_OUT,
  output logic [15:0] NEXT_INSTR_OUT,
  output logic [15:0] UTILITY_OUT,
  output logic [15:0] FIRST_INDEX_OUT,
  output logic [15:0] SECOND_INDEX_OUT,
  output logic CARRY_LINK_OUT,
  output logic OVERFLOW_OUT,
  output logic [15:0] PANEL_DISPLAY_OUT
);
  // ----------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------
  // Run input synchroniser
  // ----------------------------------------------------------
  logic [1:0] run_sync_q;
  logic run;

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      run_sync_q <= 2'h0;
    end else begin
      run_sync_q <= {run_sync_q[0], RUN_IN};
    end
  end
  assign run = run_sync_q[1];

  // ----------------------------------------------------------
  // Register state
  // ----------------------------------------------------------
  typedef struct packed {
    logic [7:0][15:0] word;
    logic [15:0] display;
    logic [15:0] rd_data;
    logic [15:0] io_rd;
    logic arr_wr_en;
    logic [15:0] arr_addr;
    logic [15:0] arr_wr_data;
  } crf_state_t;

  crf_state_t s_q, s_d;
  logic carry_q, ovf_q;
  logic halted_store;
  logic util_sel;
  logic addr_is_acc;
  logic [15:0] shown_data;
  logic carry_ld, ovf_ld;

  assign halted_store = PANEL_STORE_IN && !run;
  assign util_sel = IO_SELECT_IN == CRF_UTIL_SELECT_CODE;
  assign addr_is_acc = MEM_ADDR_IN[15:1] == CRF_ADDR_FIRST_ACC[15:1];
  assign carry_ld = halted_store && PANEL_SEL_IN == CRF_SEL_CARRY_LINK;
  assign ovf_ld = halted_store && PANEL_SEL_IN == CRF_SEL_OVERFLOW;

  // Shown data register: accumulator when address names one
  always_comb begin
    if (s_q.word[CRF_SEL_MEM_ADDR] == CRF_ADDR_FIRST_ACC) begin
      shown_data = s_q.word[CRF_SEL_FIRST_ACC];
    end else if (s_q.word[CRF_SEL_MEM_ADDR] == CRF_ADDR_SECOND_ACC) begin
      shown_data = s_q.word[CRF_SEL_SECOND_ACC];
    end else begin
      shown_data = s_q.word[CRF_SEL_MEM_DATA];
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.arr_wr_en = 1'b0;
    // Datapath writes reach the eight word registers, not the carry-link or overflow flags
    if (DP_WR_EN_IN && DP_WR_SEL_IN <= CRF_SEL_SECOND_INDEX) begin
      s_d.word[DP_WR_SEL_IN[2:0]] = DP_WR_DATA_IN;
    end
    // Memory reference: address and word pass through the registers
    if (MEM_REQ_IN) begin
      s_d.word[CRF_SEL_MEM_ADDR] = MEM_ADDR_IN;
      if (MEM_WRITE_IN) begin
        s_d.word[CRF_SEL_MEM_DATA] = MEM_WR_DATA_IN;
        if (addr_is_acc) begin
          s_d.word[{2'h0, MEM_ADDR_IN[0]}] = MEM_WR_DATA_IN;
        end else begin
          s_d.arr_wr_en = 1'b1;
          s_d.arr_addr = MEM_ADDR_IN;
          s_d.arr_wr_data = MEM_WR_DATA_IN;
        end
      end else begin
        s_d.word[CRF_SEL_MEM_DATA] = addr_is_acc ?
          s_q.word[{2'h0, MEM_ADDR_IN[0]}] : MEM_ARRAY_RD_DATA_IN;
        s_d.rd_data = s_d.word[CRF_SEL_MEM_DATA];
      end
    end
    // Utility register as I/O device
    if (IO_WR_EN_IN && util_sel) begin
      s_d.word[CRF_SEL_UTILITY] = IO_WR_DATA_IN;
    end
    if (IO_RD_EN_IN && util_sel) begin
      s_d.io_rd = s_q.word[CRF_SEL_UTILITY];
    end
    // Panel display
    if (run) begin
      s_d.display = s_d.word[CRF_SEL_UTILITY];
    end else if (PANEL_LOAD_DISPLAY_IN) begin
      s_d.display = PANEL_SWITCH_DATA_IN;
    end else if (halted_store) begin
      if (PANEL_SEL_IN <= CRF_SEL_SECOND_INDEX) begin
        s_d.word[PANEL_SEL_IN[2:0]] = s_q.display;
      end
    end else begin
      unique case (PANEL_SEL_IN)
        CRF_SEL_MEM_DATA: s_d.display = shown_data;
        CRF_SEL_CARRY_LINK: s_d.display = {15'h0000, carry_q};
        CRF_SEL_OVERFLOW: s_d.display = {15'h0000, ovf_q};
        default: s_d.display = s_q.word[PANEL_SEL_IN[2:0]];
      endcase
    end
    if (PANEL_CLEAR_DISPLAY_IN) begin
      s_d.display = CRF_WORD_RESET;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------
  // Flags
  // ----------------------------------------------------------
  crf_flag_unit u_flags (
    .clk_in(CLOCK_IN),
    .rst_n_in(rst_n),
    .carry_op_in(CARRY_OP_IN),
    .ovf_op_in(OVF_OP_IN),
    .carry_event_in(CARRY_EVENT_IN),
    .ovf_event_in(OVF_EVENT_IN),
    .carry_load_in(carry_ld),
    .carry_load_val_in(s_q.display[0]),
    .ovf_load_in(ovf_ld),
    .ovf_load_val_in(s_q.display[0]),
    .carry_out(carry_q),
    .ovf_out(ovf_q)
  );

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign FIRST_ACC_OUT = s_q.word[CRF_SEL_FIRST_ACC];
  assign SECOND_ACC_OUT = s_q.word[CRF_SEL_SECOND_ACC];
  assign MEM_ADDR_OUT = s_q.word[CRF_SEL_MEM_ADDR];
  assign MEM_DATA_OUT = s_q.word[CRF_SEL_MEM_DATA];
  assign NEXT_INSTR_OUT = s_q.word[CRF_SEL_NEXT_INSTR];
  assign UTILITY_OUT = s_q.word[CRF_SEL_UTILITY];
  assign FIRST_INDEX_OUT = s_q.word[CRF_SEL_FIRST_INDEX];
  assign SECOND_INDEX_OUT = s_q.word[CRF_SEL_SECOND_INDEX];
  assign CARRY_LINK_OUT = carry_q;
  assign OVERFLOW_OUT = ovf_q;
  assign PANEL_DISPLAY_OUT = s_q.display;
  assign MEM_RD_DATA_OUT = s_q.rd_data;
  assign IO_RD_DATA_OUT = s_q.io_rd;
  assign MEM_ARRAY_WR_EN_OUT = s_q.arr_wr_en;
  assign MEM_ARRAY_ADDR_OUT = s_q.arr_addr;
  assign MEM_ARRAY_WR_DATA_OUT = s_q.arr_wr_data;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  AST_ACC0_WRITE: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
    MEM_REQ_IN && MEM_WRITE_IN && MEM_ADDR_IN == CRF_ADDR_FIRST_ACC
    && !halted_store && !(IO_WR_EN_IN && util_sel)
    |=> FIRST_ACC_OUT == $past(MEM_WR_DATA_IN) && !MEM_ARRAY_WR_EN_OUT)
    else $error("write to location zero missed first accumulator");
  AST_ACC1_WRITE: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
    MEM_REQ_IN && MEM_WRITE_IN && MEM_ADDR_IN == CRF_ADDR_SECOND_ACC && !halted_store
    |=> SECOND_ACC_OUT == $past(MEM_WR_DATA_IN) && !MEM_ARRAY_WR_EN_OUT)
    else $error("write to location one missed second accumulator");
  AST_NO_ARRAY_LOW: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
    MEM_ARRAY_WR_EN_OUT |-> MEM_ARRAY_ADDR_OUT[15:1] != 15'h0000)
    else $error("array written at accumulator address");
  AST_MEM_ADDR: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
    MEM_REQ_IN && !halted_store && !(DP_WR_EN_IN && DP_WR_SEL_IN == CRF_SEL_MEM_ADDR)
    |=> MEM_ADDR_OUT == $past(MEM_ADDR_IN))
    else $error("memory address register not loaded");
  AST_MEM_READ: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
    MEM_REQ_IN && !MEM_WRITE_IN && !addr_is_acc |=> MEM_RD_DATA_OUT == $past(MEM_ARRAY_RD_DATA_IN))
    else $error("read word not routed through data register");
  AST_RUN_MIRROR: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
    run && !PANEL_CLEAR_DISPLAY_IN ##1 run |-> PANEL_DISPLAY_OUT == UTILITY_OUT)
    else $error("display does not mirror utility register while running");
  AST_UTIL_IO: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
    IO_RD_EN_IN && util_sel |=> IO_RD_DATA_OUT == $past(UTILITY_OUT))
    else $error("utility register read wrong");
  AST_HALT_STORE: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
    halted_store && !PANEL_LOAD_DISPLAY_IN && PANEL_SEL_IN == CRF_SEL_NEXT_INSTR
    && !DP_WR_EN_IN |=> NEXT_INSTR_OUT == $past(PANEL_DISPLAY_OUT))
    else $error("panel store to instruction address failed");
  AST_SHOW_ACC: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
    !run && PANEL_SEL_IN == CRF_SEL_MEM_DATA && MEM_ADDR_OUT == CRF_ADDR_SECOND_ACC
    && !PANEL_LOAD_DISPLAY_IN && !PANEL_STORE_IN && !PANEL_CLEAR_DISPLAY_IN
    |=> PANEL_DISPLAY_OUT == $past(SECOND_ACC_OUT))
    else $error("shown data register ignores accumulator at location one");
  COV_ACC_WRITE: cover property (@(posedge CLOCK_IN) disable iff (!rst_n)
    MEM_REQ_IN && MEM_WRITE_IN && addr_is_acc);
  COV_ARRAY_READ: cover property (@(posedge CLOCK_IN) disable iff (!rst_n)
    MEM_REQ_IN && !MEM_WRITE_IN && !addr_is_acc);
  COV_PANEL_STORE: cover property (@(posedge CLOCK_IN) disable iff (!rst_n) halted_store);
  COV_RUN_MIRROR: cover property (@(posedge CLOCK_IN) disable iff (!rst_n)
    run && IO_WR_EN_IN && util_sel);
endmodule : crf_register_file
`default_nettype wire

/* testbench/crf_mem_model.sv */
// Behavioural memory array seen behind the register file
`timescale 1ns/1ps
`default_nettype none
module crf_mem_model (
  // Clock
  input wire logic clk_in,
  // Read port, answers in the same cycle
  input wire logic [15:0] rd_addr_in,
  output logic [15:0] rd_data_out,
  // Write port
  input wire logic wr_en_in,
  input wire logic [15:0] wr_addr_in,
  input wire logic [15:0] wr_data_in
);
  logic [15:0] mem_q [16];
  logic [15:0] written_q = 16'h0000;
  // Unwritten cells give the inverted address so stale data never looks valid
  assign rd_data_out = written_q[rd_addr_in[3:0]] ? mem_q[rd_addr_in[3:0]] : ~rd_addr_in;
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in[3:0]] <= wr_data_in;
      written_q[wr_addr_in[3:0]] <= 1'b1;
    end
  end
endmodule : crf_mem_model
`default_nettype wire

/* testbench/cpu_register_file_test.sv */
// Self-checking bench for the processor register file
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_test;
  import crf_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic CLOCK_IN = 1'b0;
  logic RESET_N_IN = 1'b0;
  logic RUN_IN = 1'b0, DP_WR_EN_IN = 1'b0, MEM_REQ_IN = 1'b0, MEM_WRITE_IN = 1'b0;
  logic IO_WR_EN_IN = 1'b0, IO_RD_EN_IN = 1'b0, CARRY_EVENT_IN = 1'b0, OVF_EVENT_IN = 1'b0;
  logic PANEL_LOAD_DISPLAY_IN = 1'b0, PANEL_CLEAR_DISPLAY_IN = 1'b0, PANEL_STORE_IN = 1'b0;
  logic [15:0] DP_WR_DATA_IN = 16'h0000, MEM_ADDR_IN = 16'h0000, MEM_WR_DATA_IN = 16'h0000;
  logic [15:0] IO_WR_DATA_IN = 16'h0000, PANEL_SWITCH_DATA_IN = 16'h0000;
  logic [5:0] IO_SELECT_IN = 6'h00;
  crf_sel_t DP_WR_SEL_IN = CRF_SEL_FIRST_ACC, PANEL_SEL_IN = CRF_SEL_FIRST_ACC;
  crf_flag_op_t CARRY_OP_IN = CRF_FLAG_HOLD, OVF_OP_IN = CRF_FLAG_HOLD;
  logic [15:0] MEM_ARRAY_RD_DATA_IN, MEM_ARRAY_ADDR_OUT, MEM_ARRAY_WR_DATA_OUT, MEM_RD_DATA_OUT;
  logic [15:0] IO_RD_DATA_OUT, FIRST_ACC_OUT, SECOND_ACC_OUT, MEM_ADDR_OUT, MEM_DATA_OUT;
  logic [15:0] NEXT_INSTR_OUT, UTILITY_OUT, FIRST_INDEX_OUT, SECOND_INDEX_OUT, PANEL_DISPLAY_OUT;
  logic MEM_ARRAY_WR_EN_OUT, CARRY_LINK_OUT, OVERFLOW_OUT;
  int bad_count = 0;
  int samples_checked = 0;

  always #20 CLOCK_IN = ~CLOCK_IN;

  crf_register_file DUT (
    .CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN), .RUN_IN(RUN_IN),
    .DP_WR_EN_IN(DP_WR_EN_IN), .DP_WR_SEL_IN(DP_WR_SEL_IN), .DP_WR_DATA_IN(DP_WR_DATA_IN),
    .MEM_REQ_IN(MEM_REQ_IN), .MEM_WRITE_IN(MEM_WRITE_IN), .MEM_ADDR_IN(MEM_ADDR_IN),
    .MEM_WR_DATA_IN(MEM_WR_DATA_IN), .MEM_ARRAY_RD_DATA_IN(MEM_ARRAY_RD_DATA_IN),
    .MEM_ARRAY_WR_EN_OUT(MEM_ARRAY_WR_EN_OUT), .MEM_ARRAY_ADDR_OUT(MEM_ARRAY_ADDR_OUT),
    .MEM_ARRAY_WR_DATA_OUT(MEM_ARRAY_WR_DATA_OUT), .MEM_RD_DATA_OUT(MEM_RD_DATA_OUT),
    .IO_WR_EN_IN(IO_WR_EN_IN), .IO_RD_EN_IN(IO_RD_EN_IN), .IO_SELECT_IN(IO_SELECT_IN),
    .IO_WR_DATA_IN(IO_WR_DATA_IN), .IO_RD_DATA_OUT(IO_RD_DATA_OUT),
    .CARRY_OP_IN(CARRY_OP_IN), .OVF_OP_IN(OVF_OP_IN), .CARRY_EVENT_IN(CARRY_EVENT_IN),
    .OVF_EVENT_IN(OVF_EVENT_IN), .PANEL_SEL_IN(PANEL_SEL_IN),
    .PANEL_LOAD_DISPLAY_IN(PANEL_LOAD_DISPLAY_IN), .PANEL_SWITCH_DATA_IN(PANEL_SWITCH_DATA_IN),
    .PANEL_CLEAR_DISPLAY_IN(PANEL_CLEAR_DISPLAY_IN), .PANEL_STORE_IN(PANEL_STORE_IN),
    .FIRST_ACC_OUT(FIRST_ACC_OUT), .SECOND_ACC_OUT(SECOND_ACC_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
    .MEM_DATA_OUT(MEM_DATA_OUT), .NEXT_INSTR_OUT(NEXT_INSTR_OUT), .UTILITY_OUT(UTILITY_OUT),
    .FIRST_INDEX_OUT(FIRST_INDEX_OUT), .SECOND_INDEX_OUT(SECOND_INDEX_OUT),
    .CARRY_LINK_OUT(CARRY_LINK_OUT), .OVERFLOW_OUT(OVERFLOW_OUT),
    .PANEL_DISPLAY_OUT(PANEL_DISPLAY_OUT)
  );

  crf_mem_model MEM (
    .clk_in(CLOCK_IN), .rd_addr_in(MEM_ADDR_IN), .rd_data_out(MEM_ARRAY_RD_DATA_IN),
    .wr_en_in(MEM_ARRAY_WR_EN_OUT), .wr_addr_in(MEM_ARRAY_ADDR_OUT),
    .wr_data_in(MEM_ARRAY_WR_DATA_OUT)
  );

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Drops every strobe at the sampling edge, then lets that edge settle
  task automatic idle();
    @(posedge CLOCK_IN);
    DP_WR_EN_IN <= 1'b0;
    MEM_REQ_IN <= 1'b0;
    IO_WR_EN_IN <= 1'b0;
    IO_RD_EN_IN <= 1'b0;
    CARRY_EVENT_IN <= 1'b0;
    OVF_EVENT_IN <= 1'b0;
    CARRY_OP_IN <= CRF_FLAG_HOLD;
    OVF_OP_IN <= CRF_FLAG_HOLD;
    PANEL_LOAD_DISPLAY_IN <= 1'b0;
    PANEL_STORE_IN <= 1'b0;
    PANEL_CLEAR_DISPLAY_IN <= 1'b0;
    #1;
  endtask : idle

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLOCK_IN);
    #1;
  endtask : wait_cyc

  task automatic mem_op(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge CLOCK_IN);
    MEM_REQ_IN <= 1'b1;
    MEM_WRITE_IN <= wr;
    MEM_ADDR_IN <= a;
    MEM_WR_DATA_IN <= d;
    idle();
  endtask : mem_op

  task automatic io_op(input logic wr, input logic [5:0] s, input logic [15:0] d);
    @(posedge CLOCK_IN);
    IO_WR_EN_IN <= wr;
    IO_RD_EN_IN <= !wr;
    IO_SELECT_IN <= s;
    IO_WR_DATA_IN <= d;
    idle();
  endtask : io_op

  task automatic dp_wr(input crf_sel_t s, input logic [15:0] d);
    @(posedge CLOCK_IN);
    DP_WR_EN_IN <= 1'b1;
    DP_WR_SEL_IN <= s;
    DP_WR_DATA_IN <= d;
    idle();
  endtask : dp_wr

  task automatic flag_op(input crf_flag_op_t c, input crf_flag_op_t o, input logic ce,
                         input logic oe);
    @(posedge CLOCK_IN);
    CARRY_OP_IN <= c;
    OVF_OP_IN <= o;
    CARRY_EVENT_IN <= ce;
    OVF_EVENT_IN <= oe;
    idle();
  endtask : flag_op

  task automatic set_mode(input logic run, input crf_sel_t s);
    @(posedge CLOCK_IN);
    RUN_IN <= run;
    PANEL_SEL_IN <= s;
    wait_cyc(4);
  endtask : set_mode

  // Halted display follows its register, so the store must follow the load at once
  task automatic panel_store(input logic [15:0] sw);
    @(posedge CLOCK_IN);
    PANEL_LOAD_DISPLAY_IN <= 1'b1;
    PANEL_SWITCH_DATA_IN <= sw;
    @(posedge CLOCK_IN);
    PANEL_LOAD_DISPLAY_IN <= 1'b0;
    PANEL_STORE_IN <= 1'b1;
    idle();
  endtask : panel_store

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge CLOCK_IN);
    RESET_N_IN <= 1'b1;
    wait_cyc(3);
    chk(FIRST_ACC_OUT, 16'h0000);
    chk({15'h0000, CARRY_LINK_OUT}, 16'h0000);
    $display("reset test done");
    mem_op(1'b1, 16'h0000, 16'h1a2b);
    chk(FIRST_ACC_OUT, 16'h1a2b);
    chk(MEM_DATA_OUT, 16'h1a2b);
    chk(MEM_ADDR_OUT, 16'h0000);
    chk({15'h0000, MEM_ARRAY_WR_EN_OUT}, 16'h0000);
    mem_op(1'b1, 16'h0001, 16'hc3d4);
    chk(SECOND_ACC_OUT, 16'hc3d4);
    chk(FIRST_ACC_OUT, 16'h1a2b);
    chk({15'h0000, MEM_ARRAY_WR_EN_OUT}, 16'h0000);
    mem_op(1'b1, 16'h0005, 16'h5e6f);
    chk({15'h0000, MEM_ARRAY_WR_EN_OUT}, 16'h0001);
    chk(MEM_ARRAY_ADDR_OUT, 16'h0005);
    chk(MEM_ARRAY_WR_DATA_OUT, 16'h5e6f);
    mem_op(1'b0, 16'h0005, 16'h0000);
    chk(MEM_RD_DATA_OUT, 16'h5e6f);
    chk(MEM_DATA_OUT, 16'h5e6f);
    chk(MEM_ADDR_OUT, 16'h0005);
    mem_op(1'b0, 16'h0000, 16'h0000);
    chk(MEM_RD_DATA_OUT, 16'h1a2b);
    $display("memory test done");
    dp_wr(CRF_SEL_NEXT_INSTR, 16'h0040);
    chk(NEXT_INSTR_OUT, 16'h0040);
    dp_wr(CRF_SEL_SECOND_INDEX, 16'h9abc);
    chk(SECOND_INDEX_OUT, 16'h9abc);
    dp_wr(CRF_SEL_CARRY_LINK, 16'hffff);
    chk({15'h0000, CARRY_LINK_OUT}, 16'h0000);
    io_op(1'b1, 6'h01, 16'h0f0f);
    chk(UTILITY_OUT, 16'h0f0f);
    io_op(1'b1, 6'h02, 16'hffff);
    chk(UTILITY_OUT, 16'h0f0f);
    io_op(1'b0, 6'h01, 16'h0000);
    chk(IO_RD_DATA_OUT, 16'h0f0f);
    $display("datapath and io test done");
    set_mode(1'b1, CRF_SEL_FIRST_ACC);
    chk(PANEL_DISPLAY_OUT, 16'h0f0f);
    io_op(1'b1, 6'h01, 16'h2468);
    wait_cyc(1);
    chk(PANEL_DISPLAY_OUT, 16'h2468);
    flag_op(CRF_FLAG_HOLD, CRF_FLAG_HOLD, 1'b1, 1'b1);
    chk({15'h0000, CARRY_LINK_OUT}, 16'h0001);
    chk({15'h0000, OVERFLOW_OUT}, 16'h0001);
    flag_op(CRF_FLAG_HOLD, CRF_FLAG_HOLD, 1'b0, 1'b0);
    chk({15'h0000, CARRY_LINK_OUT}, 16'h0001);
    chk({15'h0000, OVERFLOW_OUT}, 16'h0001);
    flag_op(CRF_FLAG_CLEAR, CRF_FLAG_CLEAR, 1'b0, 1'b0);
    chk({15'h0000, CARRY_LINK_OUT}, 16'h0000);
    chk({15'h0000, OVERFLOW_OUT}, 16'h0000);
    flag_op(CRF_FLAG_COMPLEMENT, CRF_FLAG_SET, 1'b0, 1'b0);
    chk({15'h0000, CARRY_LINK_OUT}, 16'h0001);
    chk({15'h0000, OVERFLOW_OUT}, 16'h0001);
    flag_op(CRF_FLAG_COMPLEMENT, CRF_FLAG_COMPLEMENT, 1'b0, 1'b0);
    chk({15'h0000, CARRY_LINK_OUT}, 16'h0000);
    chk({15'h0000, OVERFLOW_OUT}, 16'h0001);
    flag_op(CRF_FLAG_CLEAR, CRF_FLAG_HOLD, 1'b1, 1'b0);
    chk({15'h0000, CARRY_LINK_OUT}, 16'h0001);
    $display("run and flag test done");
    set_mode(1'b0, CRF_SEL_SECOND_ACC);
    chk(PANEL_DISPLAY_OUT, 16'hc3d4);
    mem_op(1'b0, 16'h0001, 16'h0000);
    dp_wr(CRF_SEL_MEM_DATA, 16'h7777);
    set_mode(1'b0, CRF_SEL_MEM_DATA);
    chk(PANEL_DISPLAY_OUT, 16'hc3d4);
    set_mode(1'b0, CRF_SEL_FIRST_INDEX);
    panel_store(16'h55aa);
    chk(FIRST_INDEX_OUT, 16'h55aa);
    wait_cyc(2);
    chk(PANEL_DISPLAY_OUT, 16'h55aa);
    @(posedge CLOCK_IN);
    PANEL_CLEAR_DISPLAY_IN <= 1'b1;
    idle();
    chk(PANEL_DISPLAY_OUT, 16'h0000);
    set_mode(1'b0, CRF_SEL_NEXT_INSTR);
    panel_store(16'h0123);
    chk(NEXT_INSTR_OUT, 16'h0123);
    set_mode(1'b0, CRF_SEL_CARRY_LINK);
    chk(PANEL_DISPLAY_OUT, 16'h0001);
    panel_store(16'h0000);
    chk({15'h0000, CARRY_LINK_OUT}, 16'h0000);
    set_mode(1'b0, CRF_SEL_OVERFLOW);
    chk(PANEL_DISPLAY_OUT, 16'h0001);
    panel_store(16'h0000);
    chk({15'h0000, OVERFLOW_OUT}, 16'h0000);
    $display("halt panel test done");
    test_done();
  end

  initial begin
    repeat (3000) @(posedge CLOCK_IN);
    bad_count++;
    test_done();
  end
endmodule : cpu_register_file_test
`default_nettype wire
